// >>> core/efbu_core.sv
// Purpose: executes emulated ops, status updates and relative jumps
// Assumes: AXI4-Lite master keeps one write and one read at a time
// Notes: each start bit write runs one instruction in the next cycle
`timescale 1ns/1ps
`default_nettype none
module efbu_core
  import efbu_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic irq_pending,
  output logic irq_accept,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  efbu_ctrl_type ctrl_reg;
  logic [15:0] opnd_reg;
  logic [15:0] status_reg;
  logic [PC_W-1:0] pc_reg;
  logic [15:0] result_reg;
  logic exec_reg;
  logic taken_reg;
  logic irq_accept_reg;
  logic [31:0] wmask;
  logic commit;
  logic fire;
  logic hit_w;
  logic hit_r;
  logic [15:0] mask_c;
  logic [15:0] d_c;
  logic [15:0] res_c;
  logic [15:0] st_c;
  logic [PC_W-1:0] pc_c;
  logic tk_c;
  logic [PC_W-1:0] jump_pc;
  logic [31:0] merged;
  logic [31:0] opnd_m;
  logic [31:0] stat_m;
  logic [31:0] pc_m;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : lane
      assign wmask[g*8 +: 8] = {8{wstrb_reg[g]}};
    end
  endgenerate

  // Either channel may arrive first; each is parked until both are in
  assign s_axi_awready = ce && !aw_hold_reg;
  assign s_axi_wready = ce && !w_hold_reg;
  assign s_axi_arready = ce && !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign irq_accept = irq_accept_reg;
  assign commit = ce && aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign fire = ce && exec_reg;
  assign hit_w = awaddr_reg == CTRL_ADDR || awaddr_reg == OPND_ADDR ||
                 awaddr_reg == STAT_ADDR || awaddr_reg == PC_ADDR;
  assign hit_r = s_axi_araddr == CTRL_ADDR || s_axi_araddr == OPND_ADDR ||
                 s_axi_araddr == STAT_ADDR || s_axi_araddr == PC_ADDR ||
                 s_axi_araddr == RES_ADDR || s_axi_araddr == INFO_ADDR;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && !aw_hold_reg)
      begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wvalid && !w_hold_reg)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (commit)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= hit_w ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && !rvalid_reg)
      begin
        rvalid_reg <= 1'b1;
        rresp_reg <= hit_r ? RESP_OKAY : RESP_SLVERR;
        unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
          CTRL_ADDR: rdata_reg <= {6'h00, ctrl_reg.offset, 11'h000,
                                   ctrl_reg.byte_mode, ctrl_reg.op};
          OPND_ADDR: rdata_reg <= {16'h0000, opnd_reg};
          STAT_ADDR: rdata_reg <= {16'h0000, status_reg};
          PC_ADDR: rdata_reg <= {12'h000, pc_reg};
          RES_ADDR: rdata_reg <= {16'h0000, result_reg};
          INFO_ADDR: rdata_reg <= {30'h0, irq_accept_reg, taken_reg};
          default: rdata_reg <= '0;
        endcase
      end
      else if (rvalid_reg && s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end

  assign merged = merge({6'h00, ctrl_reg.offset, 11'h000,
                         ctrl_reg.byte_mode, ctrl_reg.op}, wdata_reg, wmask);
  // Named merge results, since a call result cannot be part-selected
  assign opnd_m = merge({16'h0000, opnd_reg}, wdata_reg, wmask);
  assign stat_m = merge({16'h0000, status_reg}, wdata_reg, wmask);
  assign pc_m = merge({12'h000, pc_reg}, wdata_reg, wmask);

  // Control word and start pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= '0;
      exec_reg <= 1'b0;
    end
    else if (ce)
    begin
      exec_reg <= 1'b0;
      if (commit && awaddr_reg == CTRL_ADDR)
      begin
        ctrl_reg.op <= merged[3:0];
        ctrl_reg.byte_mode <= merged[CTRL_BYTE];
        ctrl_reg.offset <= merged[CTRL_OFF_LO +: OFF_W];
        exec_reg <= wdata_reg[CTRL_GO] && wstrb_reg[3];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      opnd_reg <= '0;
    else if (commit && awaddr_reg == OPND_ADDR)
      opnd_reg <= opnd_m[15:0];
  end

  assign mask_c = ctrl_reg.byte_mode ? B_MASK : W_MASK;
  assign d_c = opnd_reg & mask_c;
  assign jump_pc = pc_reg + PC_W'({{(PC_W-OFF_W-1){ctrl_reg.offset[OFF_W-1]}},
                                   ctrl_reg.offset, 1'b0});

  function automatic logic msb(input logic [15:0] v, input logic b);
    msb = b ? v[7] : v[15];
  endfunction

  always_comb
  begin
    res_c = result_reg;
    st_c = status_reg;
    pc_c = pc_reg;
    tk_c = 1'b0;
    unique case (ctrl_reg.op)
      double_decrement_op:
      begin
        res_c = (d_c - TWO) & mask_c; // see [RQ1]
        st_c[Z_BIT] = d_c == TWO; // see [RQ2]
        st_c[C_BIT] = d_c >= TWO; // see [RQ2]
        st_c[V_BIT] = ctrl_reg.byte_mode ? (d_c == B_DDEC_V0 || d_c == B_DDEC_V1)
                                         : (d_c == W_DDEC_V0 || d_c == W_DDEC_V1); // see [RQ3]
        st_c[N_BIT] = msb(res_c, ctrl_reg.byte_mode); // see [RQ4]
      end
      increment_op:
      begin
        res_c = (d_c + ONE) & mask_c; // see [RQ10]
        st_c[Z_BIT] = d_c == mask_c; // see [RQ10]
        st_c[C_BIT] = d_c == mask_c; // see [RQ12]
        st_c[V_BIT] = d_c == (ctrl_reg.byte_mode ? B_POS_MAX : W_POS_MAX); // see [RQ11]
        st_c[N_BIT] = msb(res_c, ctrl_reg.byte_mode); // see [RQ4]
      end
      double_increment_op:
      begin
        res_c = (d_c + TWO) & mask_c; // see [RQ13]
        st_c[Z_BIT] = d_c == mask_c - ONE; // see [RQ13]
        st_c[C_BIT] = d_c >= mask_c - ONE; // see [RQ14]
        st_c[V_BIT] = d_c == (ctrl_reg.byte_mode ? B_POS_MAX : W_POS_MAX) ||
                      d_c == (ctrl_reg.byte_mode ? B_POS_MAX : W_POS_MAX) - ONE; // see [RQ15]
        st_c[N_BIT] = msb(res_c, ctrl_reg.byte_mode); // see [RQ4]
      end
      bitwise_invert_op:
      begin
        res_c = d_c ^ mask_c; // see [RQ16]
        st_c[Z_BIT] = res_c == 16'h0000;
        st_c[C_BIT] = res_c != 16'h0000; // see [RQ17]
        st_c[V_BIT] = msb(d_c, ctrl_reg.byte_mode); // see [RQ17]
        st_c[N_BIT] = msb(res_c, ctrl_reg.byte_mode); // see [RQ4]
      end
      interrupt_disable_op:
        st_c = status_reg & GIE_CLR; // see [RQ5] [RQ9]
      interrupt_enable_op:
        st_c = status_reg | GIE_MASK; // see [RQ7] [RQ9]
      jump_on_carry_op:
        tk_c = status_reg[C_BIT]; // see [RQ18]
      jump_on_zero_op:
        tk_c = status_reg[Z_BIT]; // see [RQ19]
      default:
        tk_c = 1'b0;
    endcase
    // Not taken leaves pc alone: it already names the following instruction
    if (tk_c)
      pc_c = jump_pc; // see [RQ20]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_reg <= '0;
    else if (fire)
      status_reg <= st_c; // see [RQ21]
    else if (commit && awaddr_reg == STAT_ADDR)
      status_reg <= stat_m[15:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pc_reg <= '0;
    else if (fire)
      pc_reg <= pc_c;
    else if (commit && awaddr_reg == PC_ADDR)
      pc_reg <= pc_m[PC_W-1:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      result_reg <= '0;
      taken_reg <= 1'b0;
    end
    else if (fire)
    begin
      result_reg <= res_c;
      taken_reg <= tk_c;
    end
  end

  // Acceptance uses the enable bit as it stood when the instruction began,
  // which gives the one-instruction latency of both enable and disable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_accept_reg <= 1'b0;
    else if (ce)
      irq_accept_reg <= fire && irq_pending && status_reg[GIE_BIT]; // see [RQ6] [RQ8]
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ddec_result_a: assert property (fire && ctrl_reg.op == double_decrement_op |=>
    result_reg == (($past(d_c) - TWO) & $past(mask_c))) // see [RQ1]
    else $error("double decrement result wrong");
  ddec_flags_a: assert property (fire && ctrl_reg.op == double_decrement_op |=>
    status_reg[Z_BIT] == ($past(d_c) == TWO) &&
    status_reg[C_BIT] == ($past(d_c) > ONE)) // see [RQ2]
    else $error("double decrement zero or carry wrong");
  ddec_ovf_a: assert property (fire && ctrl_reg.op == double_decrement_op &&
    !ctrl_reg.byte_mode && d_c == W_DDEC_V1 |=> status_reg[V_BIT]) // see [RQ3]
    else $error("double decrement overflow missed");
  neg_flag_a: assert property (fire && ctrl_reg.op == bitwise_invert_op &&
    ctrl_reg.byte_mode |=> status_reg[N_BIT] == result_reg[7]) // see [RQ4]
    else $error("negative flag not result top bit");
  interrupt_disable_op_clear_a: assert property (fire && ctrl_reg.op == interrupt_disable_op |=>
    status_reg == ($past(status_reg) & GIE_CLR)) // see [RQ5]
    else $error("disable changed more than enable bit");
  irq_after_interrupt_disable_op_a: assert property (fire && ctrl_reg.op == interrupt_disable_op &&
    status_reg[GIE_BIT] && irq_pending |=> irq_accept_reg) // see [RQ6]
    else $error("interrupt not accepted after disable");
  interrupt_enable_op_set_a: assert property (fire && ctrl_reg.op == interrupt_enable_op |=>
    status_reg == ($past(status_reg) | GIE_MASK)) // see [RQ7]
    else $error("enable changed more than enable bit");
  interrupt_enable_op_latency_a: assert property (fire && ctrl_reg.op == interrupt_enable_op &&
    !status_reg[GIE_BIT] |=> !irq_accept_reg) // see [RQ8]
    else $error("interrupt taken right after enable");
  mode_bits_a: assert property (fire && (ctrl_reg.op == interrupt_enable_op ||
    ctrl_reg.op == interrupt_disable_op) |=>
    $stable(status_reg[V_BIT]) && $stable(status_reg[OSC_HALT_BIT:C_BIT] &
    ~GIE_MASK[OSC_HALT_BIT:C_BIT])) // see [RQ9]
    else $error("enable or disable touched flags");
  inc_flags_a: assert property (fire && ctrl_reg.op == increment_op |=>
    status_reg[Z_BIT] == ($past(d_c) == $past(mask_c)) &&
    status_reg[C_BIT] == status_reg[Z_BIT] &&
    status_reg[V_BIT] == ($past(d_c) == ($past(ctrl_reg.byte_mode) ?
    B_POS_MAX : W_POS_MAX))) // see [RQ10] [RQ11] [RQ12]
    else $error("increment flags wrong");
  double_increment_op_flags_a: assert property (fire && ctrl_reg.op == double_increment_op |=>
    result_reg == (($past(d_c) + TWO) & $past(mask_c)) &&
    status_reg[C_BIT] == ($past(d_c) >= $past(mask_c) - ONE)) // see [RQ13] [RQ14] [RQ15]
    else $error("double increment wrong");
  inv_a: assert property (fire && ctrl_reg.op == bitwise_invert_op |=>
    result_reg == ($past(d_c) ^ $past(mask_c)) &&
    status_reg[C_BIT] == !status_reg[Z_BIT]) // see [RQ16] [RQ17]
    else $error("invert wrong");
  jump_pc_a: assert property (fire && (ctrl_reg.op == jump_on_carry_op ||
    ctrl_reg.op == jump_on_zero_op) |=> status_reg == $past(status_reg) &&
    taken_reg == ($past(ctrl_reg.op) == jump_on_carry_op ?
    $past(status_reg[C_BIT]) : $past(status_reg[Z_BIT])) &&
    pc_reg == (taken_reg ? $past(jump_pc) : $past(pc_reg))) // see [RQ18] [RQ19] [RQ20] [RQ21]
    else $error("relative jump wrong");

  ddec_cov_c: cover property (fire && ctrl_reg.op == double_decrement_op);
  interrupt_disable_op_irq_c: cover property (fire && ctrl_reg.op == interrupt_disable_op ##1 irq_accept_reg);
  jump_taken_c: cover property (fire && ctrl_reg.op == jump_on_zero_op ##1 taken_reg);
  slverr_c: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
`default_nettype wire

// >>> core/efbu_pkg.sv
// Purpose: constants and types of the emulated-op, flag and branch unit
// Assumes: AXI4-Lite register access, 32-bit data, aligned words
// Notes: every rule below binds the core side
// Operation
// [RQ1] Double decrement writes destination minus two
// [RQ2] Double decrement sets zero and carry flags
// [RQ3] Double decrement overflow on 8001h/8000h, 81h/80h
// [RQ4] Negative flag follows sized result top bit
// [RQ5] Interrupt disable ANDs status with FFF7h
// [RQ6] Interrupt still accepted right after disable
// [RQ7] Interrupt enable ORs status with 0008h
// [RQ8] Instruction after enable always runs first
// [RQ9] Enable/disable leave flags and halt bits
// [RQ10] Increment adds one, zero on all ones
// [RQ11] Increment overflow on 7FFFh or 7Fh
// [RQ12] Increment carry when destination held all ones
// [RQ13] Double increment adds two, zero on FFFEh/FEh
// [RQ14] Double increment carry on top two values
// [RQ15] Double increment overflow on 7FFEh/7FFFh, 7Eh/7Fh
// [RQ16] Invert replaces destination with its complement
// [RQ17] Invert carry is not zero, overflow if negative
// [RQ18] Carry jump branches when carry is one
// [RQ19] Zero jump branches when zero is one
// [RQ20] Taken jump adds doubled sign-extended offset
// [RQ21] Jumps change no status flag or mode bit
package efbu_pkg;
  localparam int ADDR_W = 8;
  localparam int PC_W = 20;
  localparam int OFF_W = 10;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] OPND_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] PC_ADDR = 8'h0C;
  localparam logic [ADDR_W-1:0] RES_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] INFO_ADDR = 8'h14;
  localparam int CTRL_BYTE = 4;
  localparam int CTRL_OFF_LO = 16;
  localparam int CTRL_GO = 31;
  localparam int C_BIT = 0;
  localparam int Z_BIT = 1;
  localparam int N_BIT = 2;
  localparam int GIE_BIT = 3;
  localparam int CORE_HALT_BIT = 4;
  localparam int OSC_HALT_BIT = 5;
  localparam int V_BIT = 8;
  localparam logic [15:0] GIE_MASK = 16'h0008;
  localparam logic [15:0] GIE_CLR = 16'hFFF7;
  localparam logic [15:0] W_MASK = 16'hFFFF;
  localparam logic [15:0] B_MASK = 16'h00FF;
  localparam logic [15:0] ONE = 16'h0001;
  localparam logic [15:0] TWO = 16'h0002;
  localparam logic [15:0] W_DDEC_V0 = 16'h8000;
  localparam logic [15:0] W_DDEC_V1 = 16'h8001;
  localparam logic [15:0] B_DDEC_V0 = 16'h0080;
  localparam logic [15:0] B_DDEC_V1 = 16'h0081;
  localparam logic [15:0] W_POS_MAX = 16'h7FFF;
  localparam logic [15:0] B_POS_MAX = 16'h007F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    nop_op = 4'h0,
    double_decrement_op = 4'h1,
    increment_op = 4'h2,
    double_increment_op = 4'h3,
    bitwise_invert_op = 4'h4,
    interrupt_disable_op = 4'h5,
    interrupt_enable_op = 4'h6,
    jump_on_carry_op = 4'h7,
    jump_on_zero_op = 4'h8
  } efbu_op_type;
  localparam efbu_op_type jump_unsigned_higher_same_op = jump_on_carry_op;
  localparam efbu_op_type jump_on_equal_op = jump_on_zero_op;
  typedef struct packed {
    logic [OFF_W-1:0] offset;
    logic byte_mode;
    logic [3:0] op;
  } efbu_ctrl_type;
endpackage

// >>> testbench/test_emulated_ops_flag_branch_unit.sv
// Purpose: self-checking bench for the emulated-op, flag and branch unit
// Assumes: ce dropped for a random cycle before reads, one bus transfer at a time
// Notes: a watcher pops expected bus answers from queues in issue order
`timescale 1ns/1ps
`default_nettype none
module test_emulated_ops_flag_branch_unit
  import efbu_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic irq_pending = 1'b0;
  logic irq_accept;
  logic [ADDR_W-1:0] s_axi_awaddr = 8'h00;
  logic [ADDR_W-1:0] s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [1:0] bq[$];
  logic [65:0] rq[$];
  logic [65:0] rx;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 27;
  // Ceiling sized well above the planned traffic so only a hang trips it
  localparam int LIMIT = 90000;

  efbu_core i_dut (.aclk, .aresetn, .ce, .irq_pending, .irq_accept, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  always #25 aclk = ~aclk;

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      err_total++;
      final_report();
    end
  end

  // Watcher: compares each bus answer with the oldest note
  always @(posedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready)
      cmp({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    if (s_axi_rvalid && s_axi_rready)
    begin
      rx = rq.pop_front();
      cmp({s_axi_rresp, s_axi_rdata & rx[65:34]}, {rx[33:32], rx[31:0] & rx[65:34]});
    end
  end

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    logic aw_t, w_t, b_t;
    b_t = 1'b0;
    bq.push_back(resp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_t)
    begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      @(posedge aclk);
      if (aw_t)
        s_axi_awvalid <= 1'b0;
      if (w_t)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d,
                          input logic [1:0] resp);
    logic ar_t, r_t;
    r_t = 1'b0;
    rq.push_back({m, resp, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    // Stall only while no answer is pending, so no handshake meets a frozen core
    ce <= 1'($random(seed));
    while (!r_t)
    begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      @(posedge aclk);
      ce <= 1'b1;
      if (ar_t)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  task automatic run_one(input logic [3:0] op, input logic bm, input logic [15:0] d0);
    logic [15:0] m, h, d, r, st, st0;
    logic [19:0] pc, pc0;
    logic [9:0] off;
    logic tk, irq, arith;
    st0 = 16'($random(seed)) & 16'h013F;
    pc0 = 20'($random(seed));
    off = 10'($random(seed));
    irq = 1'($random(seed));
    m = bm ? B_MASK : W_MASK;
    h = bm ? B_DDEC_V0 : W_DDEC_V0;
    d = d0 & m;
    r = d;
    st = st0;
    pc = pc0;
    tk = 1'b0;
    arith = op >= 4'h1 && op <= 4'h4;
    case (op)
      4'h1:
      begin
        r = (d - TWO) & m;
        st[Z_BIT] = d == TWO;
        st[C_BIT] = d >= TWO;
        st[V_BIT] = d == h || d == h + ONE;
      end
      4'h2:
      begin
        r = (d + ONE) & m;
        st[Z_BIT] = d == m;
        st[C_BIT] = d == m;
        st[V_BIT] = d == h - ONE;
      end
      4'h3:
      begin
        r = (d + TWO) & m;
        st[Z_BIT] = d == m - ONE;
        st[C_BIT] = d >= m - ONE;
        st[V_BIT] = d == h - ONE || d == h - TWO;
      end
      4'h4:
      begin
        r = ~d & m;
        st[Z_BIT] = r == 16'h0000;
        st[C_BIT] = r != 16'h0000;
        st[V_BIT] = (d & h) != 16'h0000;
      end
      4'h5: st = st0 & GIE_CLR;
      4'h6: st = st0 | GIE_MASK;
      4'h7: tk = st0[C_BIT];
      4'h8: tk = st0[Z_BIT];
      default: tk = 1'b0;
    endcase
    if (arith)
      st[N_BIT] = (r & h) != 16'h0000;
    if (tk)
      pc = pc0 + {{9{off[9]}}, off, 1'b0};
    irq_pending <= irq;
    axi_write(OPND_ADDR, {16'h0000, d0}, RESP_OKAY);
    axi_write(STAT_ADDR, {16'h0000, st0}, RESP_OKAY);
    axi_write(PC_ADDR, {12'h000, pc0}, RESP_OKAY);
    axi_write(CTRL_ADDR, {1'b1, 5'h00, off, 11'h000, bm, op}, RESP_OKAY);
    // Accept pulse follows the enable bit held before the instruction
    @(negedge aclk);
    cmp({33'h0, irq_accept}, {33'h0, irq & st0[GIE_BIT]});
    axi_read(RES_ADDR, arith ? 32'h0000FFFF : 32'h0, {16'h0000, r}, RESP_OKAY);
    axi_read(STAT_ADDR, 32'h0000FFFF, {16'h0000, st}, RESP_OKAY);
    axi_read(PC_ADDR, 32'h000FFFFF, {12'h000, pc}, RESP_OKAY);
    axi_read(INFO_ADDR, (op == 4'h7 || op == 4'h8) ? 32'h1 : 32'h0, {31'h0, tk}, RESP_OKAY);
    axi_read(CTRL_ADDR, 32'hFFFFFFFF, {6'h00, off, 11'h000, bm, op}, RESP_OKAY);
  endtask

  logic [15:0] vals[16] = '{16'h0000, 16'h0001, 16'h0002, 16'h007E, 16'h007F, 16'h0080,
    16'h0081, 16'h00FE, 16'h00FF, 16'h7FFE, 16'h7FFF, 16'h8000, 16'h8001, 16'hFFFE,
    16'hFFFF, 16'h1234};

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(STAT_ADDR, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
    axi_read(PC_ADDR, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
    axi_read(8'h20, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    axi_write(RES_ADDR, 32'hFFFFFFFF, RESP_SLVERR);
    for (int op = 0; op < 16; op++)
      for (int bm = 0; bm < 2; bm++)
        for (int i = 0; i < 16; i++)
          run_one(4'(op), 1'(bm), (i == 15) ? 16'($random(seed)) : vals[i]);
    repeat (3) @(posedge aclk);
    final_report();
  end
endmodule
`default_nettype wire
